// >>> rtl/upc_pkg.sv
package upc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry and register indices.
    localparam int UPC_ADDR_W   = 12;
    localparam int UPC_NREG     = 6;
    localparam int UPC_NBYTE    = 4;
    localparam int UPC_IDX_TRIM = 0;
    localparam int UPC_IDX_MODE = 1;
    localparam int UPC_IDX_SCR0 = 2;
    localparam int UPC_IDX_SCR3 = 5;

    // Byte offsets, one aligned word each.
    localparam logic [UPC_ADDR_W-1:0] UPC_OFF_TRIM = 12'h0C0;
    localparam logic [UPC_ADDR_W-1:0] UPC_OFF_MODE = 12'h0C4;
    localparam logic [UPC_ADDR_W-1:0] UPC_OFF_SCR0 = 12'h0D0;
    localparam logic [UPC_ADDR_W-1:0] UPC_OFF_SCR1 = 12'h0D4;
    localparam logic [UPC_ADDR_W-1:0] UPC_OFF_SCR2 = 12'h0D8;
    localparam logic [UPC_ADDR_W-1:0] UPC_OFF_SCR3 = 12'h0DC;
    localparam logic [UPC_ADDR_W-1:0] UPC_REG_OFF [UPC_NREG] = '{
        UPC_OFF_TRIM, UPC_OFF_MODE, UPC_OFF_SCR0, UPC_OFF_SCR1, UPC_OFF_SCR2, UPC_OFF_SCR3};

    // Writable bits per word; every other bit is reserved and reads zero.
    localparam logic [31:0] UPC_MASK_TRIM = 32'hFFF8_777F;
    localparam logic [31:0] UPC_MASK_MODE = 32'h001F_FFFF;
    localparam logic [31:0] UPC_MASK_SCR  = 32'hFFFF_FFFF;
    localparam logic [31:0] UPC_REG_MASK [UPC_NREG] = '{
        UPC_MASK_TRIM, UPC_MASK_MODE, UPC_MASK_SCR, UPC_MASK_SCR, UPC_MASK_SCR, UPC_MASK_SCR};

    // Reset values per word.
    localparam logic [31:0] UPC_RST_TRIM = 32'h0308_301C;
    localparam logic [31:0] UPC_RST_MODE = 32'h0000_0000;
    localparam logic [31:0] UPC_RST_SCR  = 32'h0000_0000;
    localparam logic [31:0] UPC_REG_RST [UPC_NREG] = '{
        UPC_RST_TRIM, UPC_RST_MODE, UPC_RST_SCR, UPC_RST_SCR, UPC_RST_SCR, UPC_RST_SCR};

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in the trim word.
    localparam int UPC_T_LF_HI  = 31;
    localparam int UPC_T_LF_LO  = 30;
    localparam int UPC_T_CP_HI  = 29;
    localparam int UPC_T_CP_LO  = 28;
    localparam int UPC_T_SW_HI  = 27;
    localparam int UPC_T_SW_LO  = 26;
    localparam int UPC_T_CUR_HI = 25;
    localparam int UPC_T_CUR_LO = 24;
    localparam int UPC_T_PE_HI  = 23;
    localparam int UPC_T_PE_LO  = 21;
    localparam int UPC_T_PE_EN  = 20;
    localparam int UPC_T_CLKSRC = 19;
    localparam int UPC_T_SQ_HI  = 14;
    localparam int UPC_T_SQ_LO  = 12;
    localparam int UPC_T_HD_HI  = 10;
    localparam int UPC_T_HD_LO  = 8;
    localparam int UPC_T_PWR    = 6;
    localparam int UPC_T_OSC    = 5;
    localparam int UPC_T_PLL    = 4;
    localparam int UPC_T_VB0    = 3;
    localparam int UPC_T_ID0    = 2;
    localparam int UPC_T_VB1    = 1;
    localparam int UPC_T_ID1    = 0;

    // Field positions in the mode word.
    localparam int UPC_M_VLD    = 20;
    localparam int UPC_M_VC_HI  = 19;
    localparam int UPC_M_VC_LO  = 15;
    localparam int UPC_M_XS_HI  = 14;
    localparam int UPC_M_XS_LO  = 13;
    localparam int UPC_M_TERM   = 12;
    localparam int UPC_M_SUSP   = 11;
    localparam int UPC_M_OM_HI  = 10;
    localparam int UPC_M_OM_LO  = 9;
    localparam int UPC_M_DPPD   = 8;
    localparam int UPC_M_DMPD   = 7;
    localparam int UPC_M_STF_LO = 6;
    localparam int UPC_M_STF_HI = 5;
    localparam int UPC_M_SER    = 4;
    localparam int UPC_M_TXEN   = 3;
    localparam int UPC_M_TXD    = 2;
    localparam int UPC_M_SE0    = 1;
    localparam int UPC_M_CEN    = 0;

    // Transceiver selection and operating modes, in encoding order.
    typedef enum logic [1:0] {UPC_XCVR_HS, UPC_XCVR_FS, UPC_XCVR_LS, UPC_XCVR_LS_ON_FS} upc_xcvr_t;
    typedef enum logic [1:0] {UPC_OPM_NORMAL, UPC_OPM_NODRIVE, UPC_OPM_RAW, UPC_OPM_NOFRAME} upc_opm_t;

endpackage : upc_pkg

// >>> rtl/upc_req_if.sv
`timescale 1ns/10ps
interface upc_req_if;
    import upc_pkg::*;
    logic                wr_en;
    logic [UPC_NREG-1:0] sel;
    logic [31:0]         wdata;
    logic [31:0]         wmask;
    logic [31:0]         rdata;
    modport front (output wr_en, sel, wdata, wmask, input rdata);
    modport bank  (input wr_en, sel, wdata, wmask, output rdata);
endinterface : upc_req_if

// >>> rtl/upc_apb_front.sv
`timescale 1ns/10ps
module upc_apb_front (
    // Clock and reset.
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // APB slave side.
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [upc_pkg::UPC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Register bank side.
    upc_req_if.front                            req
);
    import upc_pkg::*;

    logic        setup_w;
    logic        access_w;
    logic        hit_w;
    logic [31:0] prdata_q;
    logic        miss_q;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and byte-lane expansion.
    genvar gi;
    generate
        for (gi = 0; gi < UPC_NREG; gi++) begin : g_sel
            assign req.sel[gi] = (paddr == UPC_REG_OFF[gi]);
        end
        for (gi = 0; gi < UPC_NBYTE; gi++) begin : g_lane
            assign req.wmask[gi*8 +: 8] = {8{pstrb[gi]}};
        end
    endgenerate

    // Phases of a transfer; no wait states are ever inserted.
    assign setup_w   = psel & ~penable;
    assign access_w  = psel & penable;
    assign hit_w     = |req.sel;
    assign req.wr_en = access_w & pwrite & hit_w;
    assign req.wdata = pwdata;
    assign pready    = 1'b1;
    assign pslverr   = access_w & miss_q;
    assign prdata    = prdata_q;

    // Read data and the miss flag are caught in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            miss_q   <= 1'b0;
        end else if (setup_w) begin
            prdata_q <= (hit_w && !pwrite) ? req.rdata : 32'h0000_0000;
            miss_q   <= ~hit_w;
        end
    end

endmodule : upc_apb_front

// >>> rtl/upc_usb_phy_ctrl.sv
// How it works
// - Mode word bits 14:13 select HS, FS, LS, or LS packets on FS.
// - Mode word bit 12 picks HS termination at 0, FS at 1; resets 0.
// - Bits 10:9 select normal, non-driving, raw coding, or normal without framing.
// - Suspend bit 11 is active low and resets 0, so suspend holds.
// - Vendor bus from bits 19:15, active-low load from bit 20; both reset 0.
// - Bit 8 connects the plus-line pull-down when 1; resets 0.
// - Bit 7 connects the minus-line pull-down when 1; resets 0.
// - Bit 6 stuffs the low byte; bit 5 the high byte in 16-bit mode.
// - Bit 4 sends FS and LS packets parallel at 0, serial at 1.
// - Serial path gets enable low from bit 3, data bit 2, SE0 bit 1.
// - Bit 0 enables the register-driven controls; resets 0.
// - Trim word bit 6 flags digital power ready; resets 0.
// - Trim word bit 5 enables the oscillator clock output; resets 0.
// - Trim word bit 4 keeps the PLL alive in suspend; resets 1.
// - Bits 3:2 feed controller 0 VBUS and ID, reset 1; bits 1:0 controller 1, reset 0.
// - Trim word bit 19 picks crystal at 0, external core clock at 1; resets 1.
// - Bit 20 enables pre-emphasis, bits 23:21 set strength; all reset 0.
// - Bits 25:24 give the HS transmit current code; both reset 1.
// - Trim bits 14:12 give the squelch reference, resetting to 011.
// - Trim bits 10:8 give the disconnect reference; reset 0.
// - PLL and swing trims on bits 30 to 26 reset 0.
// - Four scratch words at 0xD0 to 0xDC, read/write, reset 0, no effect.
`timescale 1ns/10ps
module upc_usb_phy_ctrl (
    // Clock and reset.
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // APB slave.
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [upc_pkg::UPC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Transceiver analog trims.
    output logic                                loop_filter_trim_hi,
    output logic                                loop_filter_trim,
    output logic      [1:0]                     charge_pump_trim,
    output logic      [1:0]                     output_swing,
    output logic      [1:0]                     tx_current_code,
    output logic      [2:0]                     preemphasis_strength,
    output logic                                preemphasis_enable,
    output logic                                transceiver_clock_source,
    output logic      [2:0]                     squelch_ref,
    output logic      [2:0]                     disconnect_ref,
    // Transceiver power and clocking.
    output logic                                digital_power_ready,
    output logic                                osc_clock_out_enable,
    output logic                                pll_keep_alive,
    // OTG controller straps.
    output logic                                ctrl0_vbus_in,
    output logic                                ctrl0_id_in,
    output logic                                ctrl1_vbus_in,
    output logic                                ctrl1_id_in,
    // Transceiver mode overrides.
    output logic                                vendor_load_n,
    output logic      [4:0]                     vendor_ctrl,
    output upc_pkg::upc_xcvr_t                  xcvr_select,
    output logic                                term_select,
    output logic                                suspend_n,
    output upc_pkg::upc_opm_t                   op_mode,
    output logic                                dp_pulldown,
    output logic                                dm_pulldown,
    output logic                                tx_stuff_lo,
    output logic                                tx_stuff_hi,
    output logic                                serial_mode,
    output logic                                slow_tx_enable_n,
    output logic                                slow_tx_data,
    output logic                                slow_tx_force_se0,
    output logic                                control_enable
);
    import upc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end.
    upc_req_if req ();

    upc_apb_front u_front (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .req     (req.front)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register storage: two control words and four scratch words.
    logic [31:0] reg_q   [UPC_NREG];
    logic [31:0] reg_d   [UPC_NREG];
    logic [31:0] reg_mrg [UPC_NREG];
    logic [31:0] rd_term [UPC_NREG];
    logic [31:0] rd_or;
    logic [31:0] trim_w;
    logic [31:0] mode_w;

    genvar gi;
    generate
        for (gi = 0; gi < UPC_NREG; gi++) begin : g_reg
            // Merge enabled byte lanes, then clear the reserved bits.
            assign reg_mrg[gi] = (reg_q[gi] & ~req.wmask) | (req.wdata & req.wmask);
            assign reg_d[gi]   = (req.wr_en && req.sel[gi]) ? (reg_mrg[gi] & UPC_REG_MASK[gi])
                                                            : reg_q[gi];
            assign rd_term[gi] = req.sel[gi] ? reg_q[gi] : 32'h0000_0000;

            // Each word holds its value until a write lands on it.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    reg_q[gi] <= UPC_REG_RST[gi];
                end else begin
                    reg_q[gi] <= reg_d[gi];
                end
            end
        end
    endgenerate

    // Read data is the OR of the one selected word.
    always_comb begin
        rd_or = 32'h0000_0000;
        for (int i = 0; i < UPC_NREG; i++) begin
            rd_or = rd_or | rd_term[i];
        end
    end

    assign req.rdata = rd_or;
    assign trim_w    = reg_q[UPC_IDX_TRIM];
    assign mode_w    = reg_q[UPC_IDX_MODE];

    ////////////////////////////////////////////////////////////////////////////
    // Trim word fields drive the transceiver continuously.
    assign loop_filter_trim_hi      = trim_w[UPC_T_LF_HI];
    assign loop_filter_trim         = trim_w[UPC_T_LF_LO];
    assign charge_pump_trim         = trim_w[UPC_T_CP_HI:UPC_T_CP_LO];
    assign output_swing             = trim_w[UPC_T_SW_HI:UPC_T_SW_LO];
    assign tx_current_code          = trim_w[UPC_T_CUR_HI:UPC_T_CUR_LO];
    assign preemphasis_strength     = trim_w[UPC_T_PE_HI:UPC_T_PE_LO];
    assign preemphasis_enable       = trim_w[UPC_T_PE_EN];
    assign transceiver_clock_source = trim_w[UPC_T_CLKSRC];
    assign squelch_ref              = trim_w[UPC_T_SQ_HI:UPC_T_SQ_LO];
    assign disconnect_ref           = trim_w[UPC_T_HD_HI:UPC_T_HD_LO];
    assign digital_power_ready      = trim_w[UPC_T_PWR];
    assign osc_clock_out_enable     = trim_w[UPC_T_OSC];
    assign pll_keep_alive           = trim_w[UPC_T_PLL];

    // Controller straps come from the low trim bits.
    assign ctrl0_vbus_in = trim_w[UPC_T_VB0];
    assign ctrl0_id_in   = trim_w[UPC_T_ID0];
    assign ctrl1_vbus_in = trim_w[UPC_T_VB1];
    assign ctrl1_id_in   = trim_w[UPC_T_ID1];

    ////////////////////////////////////////////////////////////////////////////
    // Mode word fields drive the transceiver overrides continuously.
    assign vendor_load_n     = mode_w[UPC_M_VLD];
    assign vendor_ctrl       = mode_w[UPC_M_VC_HI:UPC_M_VC_LO];
    assign xcvr_select       = upc_xcvr_t'(mode_w[UPC_M_XS_HI:UPC_M_XS_LO]);
    assign term_select       = mode_w[UPC_M_TERM];
    assign suspend_n         = mode_w[UPC_M_SUSP];
    assign op_mode           = upc_opm_t'(mode_w[UPC_M_OM_HI:UPC_M_OM_LO]);
    assign dp_pulldown       = mode_w[UPC_M_DPPD];
    assign dm_pulldown       = mode_w[UPC_M_DMPD];
    assign tx_stuff_lo       = mode_w[UPC_M_STF_LO];
    assign tx_stuff_hi       = mode_w[UPC_M_STF_HI];
    assign serial_mode       = mode_w[UPC_M_SER];
    assign slow_tx_enable_n  = mode_w[UPC_M_TXEN];
    assign slow_tx_data      = mode_w[UPC_M_TXD];
    assign slow_tx_force_se0 = mode_w[UPC_M_SE0];
    assign control_enable    = mode_w[UPC_M_CEN];

    ////////////////////////////////////////////////////////////////////////////
    // Checks: writes reach the outputs one edge later, reset values hold.
    logic seen_q;
    logic wr_trim;
    logic wr_mode;
    logic wr_scr0;

    // Marks the first clock edge after reset release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    assign wr_trim = req.wr_en & req.sel[UPC_IDX_TRIM];
    assign wr_mode = req.wr_en & req.sel[UPC_IDX_MODE];
    assign wr_scr0 = req.wr_en & req.sel[UPC_IDX_SCR0];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_xcvr_select_wr: assert property (
        wr_mode && req.wmask[UPC_M_XS_HI] |=> xcvr_select == $past(req.wdata[14:13]))
        else $error("Transceiver select did not follow a write.");

    a_term_select_wr: assert property (
        wr_mode && req.wmask[UPC_M_TERM] |=> term_select == $past(req.wdata[12]))
        else $error("Termination select did not follow a write.");

    a_op_mode_wr: assert property (
        wr_mode && req.wmask[UPC_M_OM_HI] && req.wmask[UPC_M_OM_LO]
        |=> op_mode == $past(req.wdata[10:9]))
        else $error("Operating mode did not follow a write.");

    a_suspend_reset: assert property (
        !seen_q |-> !suspend_n && !control_enable && !term_select)
        else $error("Suspend or enable not at reset value.");

    a_vendor_bus_wr: assert property (
        wr_mode && req.wmask[UPC_M_VC_HI] && req.wmask[UPC_M_VC_LO]
        |=> vendor_ctrl == $past(req.wdata[19:15]) && vendor_load_n == $past(req.wdata[20]))
        else $error("Vendor control did not follow a write.");

    a_pulldown_wr: assert property (
        wr_mode && req.wmask[UPC_M_DPPD] && req.wmask[UPC_M_DMPD]
        |=> dp_pulldown == $past(req.wdata[8]) && dm_pulldown == $past(req.wdata[7]))
        else $error("Pull-down controls did not follow a write.");

    a_pulldown_reset: assert property (
        !seen_q |-> !dp_pulldown && !dm_pulldown && !vendor_load_n && vendor_ctrl == 5'h00)
        else $error("Pull-downs or vendor bus not at reset value.");

    a_serial_path_wr: assert property (
        wr_mode && req.wmask[0]
        |=> {tx_stuff_lo, tx_stuff_hi, serial_mode, slow_tx_enable_n, slow_tx_data,
             slow_tx_force_se0, control_enable} == $past(req.wdata[6:0]))
        else $error("Low mode bits did not follow a write.");

    a_mode_hold: assert property (
        !wr_mode |=> $stable(serial_mode) && $stable(op_mode) && $stable(suspend_n))
        else $error("Mode bits changed without a write.");

    a_trim_reset: assert property (
        !seen_q |-> pll_keep_alive && transceiver_clock_source && tx_current_code == 2'h3
                    && squelch_ref == 3'h3 && ctrl0_vbus_in && ctrl0_id_in)
        else $error("Trim word ones not at reset value.");

    a_trim_zero_reset: assert property (
        !seen_q |-> !digital_power_ready && !osc_clock_out_enable && !preemphasis_enable
                    && preemphasis_strength == 3'h0 && disconnect_ref == 3'h0
                    && !ctrl1_vbus_in && !ctrl1_id_in)
        else $error("Trim word zeros not at reset value.");

    a_power_wr: assert property (
        wr_trim && req.wmask[0]
        |=> {digital_power_ready, osc_clock_out_enable, pll_keep_alive} == $past(req.wdata[6:4])
            && {ctrl0_vbus_in, ctrl0_id_in, ctrl1_vbus_in, ctrl1_id_in} == $past(req.wdata[3:0]))
        else $error("Power or strap bits did not follow a write.");

    a_clock_src_wr: assert property (
        wr_trim && req.wmask[UPC_T_CLKSRC] |=> transceiver_clock_source == $past(req.wdata[19]))
        else $error("Clock source did not follow a write.");

    a_preemph_wr: assert property (
        wr_trim && req.wmask[UPC_T_PE_HI] && req.wmask[UPC_T_PE_EN]
        |=> preemphasis_strength == $past(req.wdata[23:21])
            && preemphasis_enable == $past(req.wdata[20]))
        else $error("Pre-emphasis did not follow a write.");

    a_upper_trim_wr: assert property (
        wr_trim && req.wmask[31]
        |=> {loop_filter_trim, charge_pump_trim, output_swing, tx_current_code}
            == $past(req.wdata[30:24]))
        else $error("Upper trim bits did not follow a write.");

    a_refs_wr: assert property (
        wr_trim && req.wmask[UPC_T_SQ_HI] |=> squelch_ref == $past(req.wdata[14:12])
                                              && disconnect_ref == $past(req.wdata[10:8]))
        else $error("Reference codes did not follow a write.");

    a_scratch_back: assert property (
        wr_scr0 && (&req.wmask) ##1 req.sel[UPC_IDX_SCR0]
        |-> req.rdata == $past(req.wdata))
        else $error("Scratch word lost its written value.");

    a_reserved_zero: assert property (
        req.sel[UPC_IDX_MODE] |-> req.rdata[31:21] == 11'h000)
        else $error("Reserved mode bits read nonzero.");

    a_reserved_trim: assert property (
        req.sel[UPC_IDX_TRIM] |-> req.rdata[18:15] == 4'h0 && !req.rdata[11] && !req.rdata[7])
        else $error("Reserved trim bits read nonzero.");

    a_answer_ready: assert property (
        psel && !penable
        |=> pready && prdata == ($past(pwrite) ? 32'h0000_0000 : $past(req.rdata)))
        else $error("Access phase not answered at once with the read data.");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the error answer, byte lanes and words left alone.

    a_lf_high_wr: assert property (
        wr_trim && req.wmask[31] |=> loop_filter_trim_hi == $past(req.wdata[31]))
        else $error("Loop filter high bit did not follow a write.");

    a_trim_hold: assert property (
        !wr_trim |=> $stable(squelch_ref) && $stable(tx_current_code)
                     && $stable(transceiver_clock_source) && $stable(loop_filter_trim_hi))
        else $error("Trim outputs changed without a write.");

    a_strap_hold: assert property (
        !wr_trim |=> $stable(ctrl0_vbus_in) && $stable(ctrl1_id_in)
                     && $stable(digital_power_ready))
        else $error("Strap or power bits changed without a write.");

    a_reserved_drop: assert property (
        wr_trim || wr_mode
        |=> trim_w[18:15] == 4'h0 && !trim_w[11] && !trim_w[7] && mode_w[31:21] == 11'h000)
        else $error("A write reached a reserved bit.");

    a_miss_error: assert property (
        psel && !penable && !(|req.sel) ##1 psel && penable |-> pslverr)
        else $error("Unmapped access not flagged.");

    a_hit_no_error: assert property (
        psel && !penable && (|req.sel) ##1 psel && penable |-> !pslverr)
        else $error("Mapped access flagged as an error.");

    a_byte_keep: assert property (
        wr_scr0 && !req.wmask[8]
        |=> reg_q[UPC_IDX_SCR0][15:8] == $past(reg_q[UPC_IDX_SCR0][15:8]))
        else $error("A disabled byte lane changed a scratch word.");

    a_scratch_hold: assert property (
        !wr_scr0 |=> $stable(reg_q[UPC_IDX_SCR0]))
        else $error("Scratch word changed without a write.");

    c_suspend_release: cover property (!suspend_n ##1 suspend_n);
    c_mode_write:      cover property (wr_mode ##1 control_enable);
    c_scratch_write:   cover property (wr_scr0 ##1 req.sel[UPC_IDX_SCR0]);
    c_unmapped:        cover property (pslverr);
    c_byte_lanes:      cover property (wr_scr0 && !(&req.wmask));

endmodule : upc_usb_phy_ctrl

// >>> tb/upc_xcvr_model.sv
`timescale 1ns/10ps
module upc_xcvr_model (
    // Control words as the transceiver receives them.
    input  wire logic [31:0] trim_w,
    input  wire logic [31:0] mode_w,
    // Transceiver state.
    output logic             suspended,
    output logic             susp_clocks_on
);
    // The transceiver is held in suspend while the active-low control is low.
    assign suspended = !mode_w[11];
    // Suspend clocks run while awake, or in suspend while the PLL is kept alive.
    assign susp_clocks_on = mode_w[11] || trim_w[4];
endmodule : upc_xcvr_model

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
    import upc_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, se, susp, clk_on;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    wire  [31:0] tw, mw;
    logic [3:0]  pstrb = 4'h0;
    int          err_total = 0, n_checks = 0;
    // Reserved positions of the output words carry no signal.
    assign tw[18:15] = 4'h0;
    assign tw[11]    = 1'b0;
    assign tw[7]     = 1'b0;
    assign mw[31:21] = 11'h000;
    // Each output lands in the bit of the word that drives it.
    upc_usb_phy_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .loop_filter_trim_hi(tw[31]),
        .loop_filter_trim(tw[30]), .charge_pump_trim(tw[29:28]), .output_swing(tw[27:26]),
        .tx_current_code(tw[25:24]), .preemphasis_strength(tw[23:21]),
        .preemphasis_enable(tw[20]), .transceiver_clock_source(tw[19]),
        .squelch_ref(tw[14:12]), .disconnect_ref(tw[10:8]), .digital_power_ready(tw[6]),
        .osc_clock_out_enable(tw[5]), .pll_keep_alive(tw[4]), .ctrl0_vbus_in(tw[3]),
        .ctrl0_id_in(tw[2]), .ctrl1_vbus_in(tw[1]), .ctrl1_id_in(tw[0]),
        .vendor_load_n(mw[20]), .vendor_ctrl(mw[19:15]), .xcvr_select(mw[14:13]),
        .term_select(mw[12]), .suspend_n(mw[11]), .op_mode(mw[10:9]), .dp_pulldown(mw[8]),
        .dm_pulldown(mw[7]), .tx_stuff_lo(mw[6]), .tx_stuff_hi(mw[5]), .serial_mode(mw[4]),
        .slow_tx_enable_n(mw[3]), .slow_tx_data(mw[2]), .slow_tx_force_se0(mw[1]),
        .control_enable(mw[0]));
    upc_xcvr_model u_xcvr (.trim_w(tw), .mode_w(mw), .suspended(susp),
        .susp_clocks_on(clk_on));
    // Free-running bus clock.
    initial forever #25 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // One APB transfer; read data and error are taken at the completing edge.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        if (n >= 20) results();
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : xfer
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk("trim reset", 32'h0308_301C, tw);
        chk("mode reset", 32'h0, mw);
        chk("suspended", 32'h1, {31'h0, susp});
        chk("clocks on", 32'h1, {31'h0, clk_on});
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, UPC_REG_OFF[i], 32'h0, 4'hF);
            chk("reg reset", (i == 0) ? 32'h0308_301C : 32'h0, rd);
        end
        xfer(1'b1, UPC_OFF_TRIM, 32'hFFFF_FFFF, 4'hF);
        xfer(1'b1, UPC_OFF_MODE, 32'hFFFF_FFFF, 4'hF);
        chk("trim outs", 32'hFFF8_777F, tw);
        chk("mode outs", 32'h001F_FFFF, mw);
        xfer(1'b0, UPC_OFF_MODE, 32'h0, 4'hF);
        chk("mode read", 32'h001F_FFFF, rd);
        // Every selection code against a different mode code.
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, UPC_OFF_MODE, 32'((i << 13) | ((3 - i) << 9)), 4'hF);
            chk("codes", 32'((i << 13) | ((3 - i) << 9)), mw);
        end
        for (int i = 2; i < 6; i++) xfer(1'b1, UPC_REG_OFF[i], 32'hA5A5_0000 | i, 4'hF);
        xfer(1'b1, UPC_OFF_SCR0, 32'h1234_5678, 4'h5);
        for (int i = 2; i < 6; i++) begin
            xfer(1'b0, UPC_REG_OFF[i], 32'h0, 4'h0);
            chk("scratch", (i == 2) ? 32'hA534_0078 : 32'hA5A5_0000 | i, rd);
        end
        chk("scratch fx", 32'h0000_6000, mw);
        xfer(1'b1, 12'h0C8, 32'hFFFF_FFFF, 4'hF);
        xfer(1'b0, 12'h0C8, 32'h0, 4'hF);
        chk("unmapped", 32'h0, rd);
        chk("slverr", 32'h1, {31'h0, se});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("trim again", 32'h0308_301C, tw);
        chk("mode again", 32'h0, mw);
        xfer(1'b0, UPC_OFF_SCR1, 32'h0, 4'hF);
        chk("scratch again", 32'h0, rd);
        results();
    end
endmodule : tb
